//--- psic_map.vh
// Purpose: constants for the pipelined sram input control block
// Assumes: included by psic_top.v only
// Notes: burst order codes follow the burst-order strap level
//
// Summary of operation
// RULE_01: all synchronous inputs taken on rising clock
// RULE_02: address registered on strobe with chip selected
// RULE_03: low two address bits load burst counter
// RULE_04: burst counter advances when step sampled low
// RULE_05: byte lane writes need qualifier low
// RULE_06: qualifier high blocks byte-selective writes
// RULE_07: global write writes every lane
// RULE_08: primary select active low, combined with others
// RULE_09: processor strobe ignored when primary select high
// RULE_10: depth select hi is active high select
// RULE_11: selects sampled only on address load cycles
// RULE_12: both strobes low, processor strobe wins
// RULE_13: depth select lo is active low select
// RULE_14: strap low linear, high interleaved burst
// RULE_15: selected only when all three selects active
`ifndef PSIC_MAP_VH
`define PSIC_MAP_VH
`define PSIC_ADDR_W 19
`define PSIC_LANES 4
`define PSIC_BURST_W 2
`define PSIC_ORDER_LINEAR 1'b0
`define PSIC_ORDER_INTERLEAVED 1'b1
`define PSIC_SRC_NONE 2'h0
`define PSIC_SRC_PROC 2'h1
`define PSIC_SRC_CTRL 2'h2
`define PSIC_SRC_ADV 2'h3
`endif

//--- psic_top.v
// Purpose: input capture, chip select, burst counter and write decode of a pipelined sram
// Assumes: inputs arrive from a synchronous bus master on mclk, so no synchroniser
// Notes: burst order strap is captured after reset release, then held static
`timescale 1ns/1ps
`include "psic_map.vh"
module psic_top #(
   parameter ADDR_W = `PSIC_ADDR_W,
   parameter LANES = `PSIC_LANES
) (
   input wire mclk,
   input wire arst_n,
   input wire [ADDR_W-1:0] addr_in,
   input wire primary_select_n,
   input wire depth_select_hi,
   input wire depth_select_lo_n,
   input wire processor_addr_strobe_n,
   input wire controller_addr_strobe_n,
   input wire burst_step_n,
   input wire [LANES-1:0] byte_lane_write_select,
   input wire byte_write_qualifier_n,
   input wire all_bytes_write_n,
   input wire burst_order_strap,
   output reg [ADDR_W-1:0] mem_addr,
   output reg [1:0] burst_count,
   output reg selected,
   output reg [LANES-1:0] lane_write_en,
   output reg write_cycle,
   output reg [1:0] access_src,
   output reg burst_order
);

// ==========================================
// select and strobe decode
reg [1:0] burst_base;
reg strap_taken;
wire all_selected;
wire proc_load;
wire ctrl_load;
wire addr_load;
wire good_load;
wire step;
wire lane_phase;
wire [1:0] next_count;
wire [1:0] burst_index;
wire [1:0] next_offset;
wire [LANES-1:0] next_lanes;

// RULE_08 RULE_10 RULE_13 RULE_15: three-way select
assign all_selected = ~primary_select_n & depth_select_hi & ~depth_select_lo_n;
// RULE_09 RULE_12: processor strobe precedence
assign proc_load = ~processor_addr_strobe_n & ~primary_select_n;
// RULE_02: controller strobe load
assign ctrl_load = ~proc_load & ~controller_addr_strobe_n;
assign addr_load = proc_load | ctrl_load;
assign good_load = addr_load & all_selected;
// processor strobe cycles are always reads; writes come a cycle later
assign lane_phase = (good_load & ~proc_load) | (~addr_load & selected);
// RULE_04: advance only within a burst
assign step = ~addr_load & ~burst_step_n & selected;
assign next_count = burst_count + 2'h1;
// RULE_14: linear adds, interleaved xors
// interleaved walks base xor index, index counted from the load
assign burst_index = next_count - burst_base;
assign next_offset = (burst_order == `PSIC_ORDER_LINEAR) ? next_count : (burst_base ^ burst_index);

// ==========================================
// write decode
genvar lane;
generate
   for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      // RULE_05 RULE_06 RULE_07: global, byte, none
      assign next_lanes[lane] = ~all_bytes_write_n |
         (~byte_write_qualifier_n & ~byte_lane_write_select[lane]);
   end
endgenerate

// ==========================================
// capture registers
// RULE_01: all synchronous inputs on rising mclk
// strap caught once after release; it must stay static
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      burst_order <= `PSIC_ORDER_INTERLEAVED;
      strap_taken <= 1'b0;
   end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      burst_order <= burst_order_strap;
   end
end

// RULE_11: selects only sampled on loads
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      selected <= 1'b0;
   end else if (addr_load) begin
      selected <= all_selected;
   end
end

// ==========================================
// address and burst counter
// RULE_02: address register
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      mem_addr <= {ADDR_W{1'b0}};
   end else if (good_load) begin
      mem_addr <= addr_in;
   end else if (step) begin
      mem_addr <= {mem_addr[ADDR_W-1:2], next_offset};
   end
end

// RULE_03 RULE_04: counter load and advance
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      burst_count <= 2'h0;
      burst_base <= 2'h0;
   end else if (good_load) begin
      burst_count <= addr_in[1:0];
      burst_base <= addr_in[1:0];
   end else if (step) begin
      burst_count <= next_count;
   end
end

// access source report
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      access_src <= `PSIC_SRC_NONE;
   end else if (good_load) begin
      access_src <= proc_load ? `PSIC_SRC_PROC : `PSIC_SRC_CTRL;
   end else if (addr_load) begin
      access_src <= `PSIC_SRC_NONE;
   end else if (step) begin
      access_src <= `PSIC_SRC_ADV;
   end
end

// ==========================================
// write lane register
// RULE_05 RULE_07: lanes stand one cycle
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      lane_write_en <= {LANES{1'b0}};
      write_cycle <= 1'b0;
   end else if (lane_phase) begin
      lane_write_en <= next_lanes;
      write_cycle <= |next_lanes;
   end else begin
      lane_write_en <= {LANES{1'b0}};
      write_cycle <= 1'b0;
   end
end

endmodule // psic_top

//--- psic_sva.sv
// Purpose: port checker. Assumes: one clock. Notes: bound below
`timescale 1ns/1ps
module psic_sva #(parameter ADDR_W=19, LANES=4) (input wire mclk, arst_n, selected,
 processor_addr_strobe_n, controller_addr_strobe_n, primary_select_n, depth_select_hi,
 depth_select_lo_n, burst_step_n, byte_write_qualifier_n, all_bytes_write_n,
 input wire [ADDR_W-1:0] addr_in, mem_addr, input wire [LANES-1:0] byte_lane_write_select,
 lane_write_en, input wire [1:0] burst_count, access_src);
   wire ld = !processor_addr_strobe_n && !primary_select_n || !controller_addr_strobe_n;
   wire cs = !primary_select_n && depth_select_hi && !depth_select_lo_n;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   property p_ld; ld && cs |=> selected && burst_count == $past(addr_in[1:0])
    && mem_addr[ADDR_W-1:2] == $past(addr_in[ADDR_W-1:2]); endproperty
   a_ld: assert property (p_ld) else $error("load");
   property p_st; !ld && selected && !burst_step_n |=> access_src == 2'h3
    && burst_count == $past(burst_count) + 2'h1; endproperty
   a_st: assert property (p_st) else $error("step");
   property p_bl; !ld && selected && all_bytes_write_n && !byte_write_qualifier_n
    |=> lane_write_en == ~$past(byte_lane_write_select); endproperty
   a_bl: assert property (p_bl) else $error("lanes");
   property p_q; all_bytes_write_n && byte_write_qualifier_n |=> lane_write_en == '0; endproperty
   a_q: assert property (p_q) else $error("qual");
   property p_gw; !ld && selected && !all_bytes_write_n |=> &lane_write_en; endproperty
   a_gw: assert property (p_gw) else $error("global");
   property p_ds; ld && !cs |=> !selected && access_src == 2'h0; endproperty
   a_ds: assert property (p_ds) else $error("desel");
   property p_kp; !ld |=> $stable(selected); endproperty
   a_kp: assert property (p_kp) else $error("sel kept");
   property p_pr; !processor_addr_strobe_n && !controller_addr_strobe_n && cs
    |=> access_src == 2'h1 && lane_write_en == '0; endproperty
   a_pr: assert property (p_pr) else $error("prio");
endmodule // psic_sva
bind psic_top psic_sva #(.ADDR_W(ADDR_W), .LANES(LANES)) u_sva(.*);

//--- psic_host.sv
// Purpose: bus master model. Assumes: one clock. Notes: one cycle per call
`timescale 1ns/1ps
module psic_host (input wire mclk, output reg [18:0] addr_in,
 output reg [3:0] byte_lane_write_select, output wire primary_select_n, depth_select_hi,
 depth_select_lo_n, processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
 byte_write_qualifier_n, all_bytes_write_n);
   reg [7:0] ctl = 8'h5f;
   initial addr_in = '0;
   initial byte_lane_write_select = 4'hf;
   assign {primary_select_n, depth_select_hi, depth_select_lo_n, processor_addr_strobe_n,
    controller_addr_strobe_n, burst_step_n, byte_write_qualifier_n, all_bytes_write_n} = ctl;
   task go(input [18:0] a, input [7:0] c, input [3:0] b);
      @(posedge mclk);
      #1 ctl = c;
      addr_in = a;
      byte_lane_write_select = b;
   endtask
endmodule // psic_host

//--- psic_test.sv
// Purpose: bench. Assumes: 20 MHz. Notes: host model drives inputs
`timescale 1ns/1ps
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
module psic_test;
   reg mclk = 0;
   reg arst_n = 0;
   reg strap = 1;
   int n_errors = 0;
   int cmp_count = 0;
   wire [18:0] addr_in, mem_addr;
   wire [3:0] byte_lane_write_select, lane_write_en;
   wire [1:0] burst_count, access_src;
   wire primary_select_n, depth_select_hi, depth_select_lo_n, processor_addr_strobe_n,
    controller_addr_strobe_n, burst_step_n, byte_write_qualifier_n, all_bytes_write_n,
    selected, write_cycle, burst_order;
   always #25 mclk = ~mclk;
   psic_host u_host(.*);
   psic_top u_dut(.*, .burst_order_strap(strap));
   task t_ctrl;
      u_host.go(19'h12347, 8'h56, 4'hf);
      u_host.go(19'h0, 8'h5b, 4'hf);
      `CK({burst_count, access_src, lane_write_en}, 8'hef)
      `CK(mem_addr[18:2], 17'h48d1)
      `CK(write_cycle, 1'b1)
      u_host.go(19'h0, 8'h5d, 4'ha);
      `CK({burst_count, access_src}, 4'h3)
      `CK(mem_addr[1:0], 2'h2)
      u_host.go(19'h0, 8'h5f, 4'h0);
      `CK(lane_write_en, 4'h5)
      u_host.go(19'h0, 8'h5f, 4'hf);
      `CK(lane_write_en, 4'h0)
   endtask
   task t_proc;
      u_host.go(19'h2, 8'h46, 4'hf);
      u_host.go(19'h1, 8'hcf, 4'hf);
      `CK({access_src, lane_write_en}, 6'h10)
      u_host.go(19'h3, 8'h77, 4'hf);
      `CK({access_src, burst_count}, 4'h6)
      u_host.go(19'h0, 8'h1b, 4'hf);
      `CK({selected, access_src}, 3'h0)
      u_host.go(19'h0, 8'h5f, 4'hf);
      `CK(burst_count, 2'h2)
   endtask
   task t_linear;
      @(posedge mclk);
      #1 arst_n = 0;
      strap = 0;
      @(posedge mclk);
      #1 arst_n = 1;
      `CK({selected, burst_order}, 2'h1)
      u_host.go(19'h1, 8'h57, 4'hf);
      u_host.go(19'h0, 8'h5b, 4'hf);
      `CK(burst_order, 1'b0)
      u_host.go(19'h0, 8'h5b, 4'hf);
      `CK(mem_addr[1:0], 2'h2)
      u_host.go(19'h0, 8'h5f, 4'hf);
      `CK(mem_addr[1:0], 2'h3)
   endtask
   task print_verdict;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1 arst_n = 1;
      t_ctrl;
      t_proc;
      `CK(burst_order, 1'b1)
      t_linear;
      print_verdict;
   end
endmodule // psic_test
